/* File: testbench.sv */
// Self-checking testbench for the calibration and limit register bank
`timescale 1ns/1ns
module testbench;
    // Identity values are arbitrary
    localparam logic [15:0] MAKER = 16'h3C3C;
    localparam logic [7:0] PART = 8'h21;
    localparam logic [7:0] REV = 8'h02;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic conv_done = 1'b0;
    logic [2:0] conv_ch = 3'h0;
    logic [15:0] conv_raw = 16'h0000;
    logic [2:0] conv_sel = 3'h0;
    logic ptr_wr, reg_wr, reg_rd_ack, block_mode, locked, otp_oe_n, ots_oe_n;
    logic [7:0] ptr_data;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [11:0] ideality_denom;
    logic [4:0] primary_status, secondary_status;
    int miscompares = 0;
    int n_checks = 0;

    always #5 ref_clk = ~ref_clk;

    tsclr_regs #(.MAKER_CODE(MAKER), .PART_CODE(PART), .REVISION(REV)) i_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .ptr_wr(ptr_wr),
        .ptr_data(ptr_data),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd_ack(reg_rd_ack),
        .reg_rdata(reg_rdata),
        .block_mode(block_mode),
        .locked(locked),
        .conv_done(conv_done),
        .conv_ch(conv_ch),
        .conv_raw(conv_raw),
        .conv_sel(conv_sel),
        .ideality_denom(ideality_denom),
        .primary_status(primary_status),
        .secondary_status(secondary_status),
        .overtemp_output_primary_oe_n(otp_oe_n),
        .overtemp_output_secondary_oe_n(ots_oe_n)
    );

    tsclr_host i_host (
        .ref_clk(ref_clk),
        .ptr_wr(ptr_wr),
        .ptr_data(ptr_data),
        .reg_wr(reg_wr),
        .reg_wdata(reg_wdata),
        .reg_rd_ack(reg_rd_ack),
        .reg_rdata(reg_rdata)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test

    task automatic conv(input logic [2:0] ch, input logic [15:0] raw);
        @(negedge ref_clk);
        conv_done = 1'b1;
        conv_ch = ch;
        conv_raw = raw;
        @(negedge ref_clk);
        conv_done = 1'b0;
        conv_raw = ~raw;
        repeat (2) @(negedge ref_clk);
    endtask : conv

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_eta;
        logic [11:0] dn [5] = '{12'h828, 12'h8A7, 12'h7A8, 12'h828, 12'h827};
        for (int i = 0; i < 4; i++)
        begin
            i_host.rd(tsclr_pkg::PTR_ETA[i], d);
            chk("eta reset", d, 16'h0000);
        end
        chk("oe reset", {14'h0000, otp_oe_n, ots_oe_n}, 16'h0003);
        i_host.wr(8'h41, 16'h7F00);
        i_host.wr(8'h49, 16'h8000);
        i_host.wr(8'h59, 16'hFF00);
        i_host.rd(8'h41, d);
        chk("eta readback", d, 16'h7F00);
        for (int i = 0; i < 5; i++)
        begin
            @(negedge ref_clk);
            conv_sel = 3'(i);
            repeat (2) @(negedge ref_clk);
            chk("denom", 16'(ideality_denom), 16'(dn[i]));
        end
        $display("test eta done");
    endtask : t_eta

    task automatic t_mirror;
        i_host.wr(8'h40, 16'h0100);
        i_host.wr(8'h48, 16'hFFF8);
        conv(3'h0, 16'h0800);
        conv(3'h1, 16'h1900);
        conv(3'h2, 16'h1900);
        i_host.rd(8'h80, d);
        chk("mirror0", d, 16'h0800);
        chk("block_mode", 16'(block_mode), 16'h0001);
        i_host.nxt(d);
        chk("mirror1", d, 16'h1A00);
        i_host.nxt(d);
        chk("mirror2", d, 16'h18F8);
        i_host.rd(8'h84, d);
        chk("mirror4", d, 16'h0000);
        i_host.nxt(d);
        chk("mirror wrap", d, 16'h0800);
        $display("test mirror done");
    endtask : t_mirror

    task automatic t_limits;
        i_host.wr(8'h40, 16'h0000);
        i_host.wr(8'h38, 16'h0280); // 5 degrees
        i_host.wr(8'h42, 16'h1900); // 50 degrees
        conv(3'h1, 16'h1900);
        chk("prim set", 16'(primary_status), 16'h0002);
        chk("prim pin", 16'(otp_oe_n), 16'h0000);
        chk("sec off", 16'(secondary_status), 16'h0000);
        conv(3'h1, 16'h1780); // 47 degrees, inside band
        chk("prim hold", 16'(primary_status), 16'h0002);
        conv(3'h1, 16'h1680); // 45 degrees, edge of band
        chk("prim clr", 16'(primary_status), 16'h0000);
        chk("prim pin off", 16'(otp_oe_n), 16'h0001);
        i_host.wr(8'h43, 16'h1900);
        conv(3'h1, 16'h1900);
        chk("sec set", 16'(secondary_status), 16'h0002);
        chk("sec pin", 16'(ots_oe_n), 16'h0000);
        i_host.wr(8'h43, 16'h7FC0);
        repeat (2) @(negedge ref_clk);
        chk("sec disabled", 16'(secondary_status), 16'h0000);
        $display("test limits done");
    endtask : t_limits

    task automatic t_lock;
        i_host.wr(8'hC4, 16'h5CA6);
        i_host.rd(8'hC4, d);
        chk("lock on", d, 16'h8000);
        chk("locked", 16'(locked), 16'h0001);
        i_host.wr(8'h42, 16'h0000);
        i_host.rd(8'h42, d);
        chk("limit kept", d, 16'h1900);
        i_host.wr(8'hC4, 16'h1234);
        i_host.rd(8'hC4, d);
        chk("bad key", d, 16'h8000);
        i_host.wr(8'hC4, 16'hEB19);
        i_host.rd(8'hC4, d);
        chk("lock off", d, 16'h0000);
        i_host.wr(8'h42, 16'hC040);
        i_host.rd(8'h42, d);
        chk("limit written", d, 16'hC040);
        $display("test lock done");
    endtask : t_lock

    task automatic t_id;
        i_host.wr(8'hFE, 16'h0000);
        i_host.rd(8'hFE, d);
        chk("maker", d, MAKER);
        i_host.rd(8'hFF, d);
        chk("part", d, {REV, PART});
        i_host.rd(8'h20, d);
        chk("unmapped", d, 16'h0000);
        $display("test id done");
    endtask : t_id

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        t_eta();
        t_mirror();
        t_limits();
        t_lock();
        t_id();
        stop_test();
    end

    initial
    begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule : testbench

/* File: tsclr_host.sv */
// Host-side model of the serial engine on the register port
`timescale 1ns/1ns
module tsclr_host (
    input wire logic ref_clk, // 100 MHz clock
    output logic ptr_wr, // pointer load
    output logic [7:0] ptr_data, // pointer value
    output logic reg_wr, // word write
    output logic [15:0] reg_wdata, // word to write
    output logic reg_rd_ack, // word sent
    input wire logic [15:0] reg_rdata // word at pointer
);
    initial
    begin
        ptr_wr = 1'b0;
        ptr_data = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd_ack = 1'b0;
    end

    // Caller hands whole signed words, already sign extended
    task automatic wr(input logic [7:0] p, input logic [15:0] v);
        @(negedge ref_clk);
        ptr_wr = 1'b1;
        ptr_data = p;
        @(negedge ref_clk);
        ptr_wr = 1'b0;
        ptr_data = ~p;
        reg_wr = 1'b1;
        reg_wdata = v;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        // Released data inverted so stale values cannot pass
        reg_wdata = ~v;
    endtask : wr

    task automatic rd(input logic [7:0] p, output logic [15:0] v);
        @(negedge ref_clk);
        ptr_wr = 1'b1;
        ptr_data = p;
        @(negedge ref_clk);
        ptr_wr = 1'b0;
        ptr_data = ~p;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask : rd

    task automatic nxt(output logic [15:0] v);
        @(negedge ref_clk);
        reg_rd_ack = 1'b1;
        @(negedge ref_clk);
        reg_rd_ack = 1'b0;
        @(negedge ref_clk);
        v = reg_rdata;
    endtask : nxt
endmodule : tsclr_host

/* File: tsclr_limit_cmp.sv */
// One limit comparator with common hysteresis
`timescale 1ns/1ns
module tsclr_limit_cmp (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic sample, // new result stored this cycle
    input wire logic [12:0] temp_code, // signed, 1/16 degree
    input wire logic [9:0] limit_code, // signed, 1/2 degree
    input wire logic [7:0] hyst_code, // unsigned, 1 degree
    output logic over // limit flag
);
    typedef struct packed {
        logic flag;
    } tsclr_cmp_state_t;

    tsclr_cmp_state_t s;
    tsclr_cmp_state_t n;
    logic signed [15:0] t16;
    logic signed [15:0] lim16;
    logic signed [15:0] clr16;
    logic disabled;

    // All compared in 1/16 degree; worst case clear point still fits
    assign t16 = {{3{temp_code[12]}}, temp_code};
    assign lim16 = {{3{limit_code[9]}}, limit_code, 3'h0};
    assign clr16 = lim16 - {4'h0, hyst_code, 4'h0};
    assign disabled = (limit_code == tsclr_pkg::LIM_DISABLE);

    always_comb
    begin
        n = s;
        if (disabled)
        begin
            n.flag = 1'b0;
        end
        else if (sample)
        begin
            if (t16 >= lim16)
            begin
                n.flag = 1'b1;
            end
            else if (t16 <= clr16)
            begin
                n.flag = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s <= '0;
        end
        else
        begin
            s <= n;
        end
    end

    assign over = s.flag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_cmp_disable;
        @(posedge ref_clk) disable iff (!nrst)
        disabled |=> !over;
    endproperty
    a_cmp_disable: assert property (p_cmp_disable)
        else $error("disabled limit left flag set");

    property p_cmp_hold;
        @(posedge ref_clk) disable iff (!nrst)
        over && sample && !disabled && (t16 > clr16) |=> over;
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("flag cleared inside hysteresis band");

    c_cmp_trip: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(over));
endmodule : tsclr_limit_cmp

/* File: tsclr_pkg.sv */
// Constants shared by the calibration and limit register bank
package tsclr_pkg;
    // ------------------------------------------------------------
    // Pointer addresses
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_HYST = 8'h38;
    // Index 0 is the local channel, 1..4 the remote channels
    localparam logic [4:0][7:0] PTR_LIM_P = {8'h5A, 8'h52, 8'h4A, 8'h42, 8'h39};
    localparam logic [4:0][7:0] PTR_LIM_S = {8'h5B, 8'h53, 8'h4B, 8'h43, 8'h3A};
    // Index 0 is remote channel 1
    localparam logic [3:0][7:0] PTR_OFFS = {8'h58, 8'h50, 8'h48, 8'h40};
    localparam logic [3:0][7:0] PTR_ETA = {8'h59, 8'h51, 8'h49, 8'h41};
    localparam logic [7:0] PTR_MIRROR_FIRST = 8'h80;
    localparam logic [7:0] PTR_MIRROR_LAST = 8'h84;
    localparam logic [7:0] PTR_LOCK = 8'hC4;
    localparam logic [7:0] PTR_MAKER = 8'hFE;
    localparam logic [7:0] PTR_PART = 8'hFF;

    // ------------------------------------------------------------
    // Keys and fixed read values
    // ------------------------------------------------------------
    localparam logic [15:0] KEY_LOCK = 16'h5CA6;
    localparam logic [15:0] KEY_UNLOCK = 16'hEB19;
    localparam logic [15:0] LOCK_READ_ON = 16'h8000;
    localparam logic [15:0] LOCK_READ_OFF = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] ETA_RESET = 16'h0000;
    localparam logic [15:0] OFFS_RESET = 16'h0000;
    // Reset limits sit at the disable code, 255.5 degrees
    localparam logic [15:0] LIM_RESET = 16'h7FC0;
    localparam logic [15:0] HYST_RESET = 16'h0000;
    localparam logic [15:0] TEMP_RESET = 16'h0000;
    localparam logic [7:0] PTR_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field layouts
    // ------------------------------------------------------------
    localparam int ETA_MSB = 15;
    localparam int ETA_LSB = 8;
    localparam int LIM_MSB = 15;
    localparam int LIM_LSB = 6;
    localparam int HYST_MSB = 14;
    localparam int HYST_LSB = 7;
    localparam int TEMP_MSB = 15;
    localparam int TEMP_LSB = 3;
    localparam logic [9:0] LIM_DISABLE = 10'h1FF;
    localparam logic [11:0] ETA_NOMINAL_DENOM = 12'h828;
    localparam int NUM_CH = 5;
    localparam int NUM_REMOTE = 4;
endpackage : tsclr_pkg

/* File: tsclr_regs.sv */
// Calibration, limit, mirror, lock and identity register bank
// ------------------------------------------------------------
// Summary of operation
// - Four ideality registers, each for own channel
// - Ideality equals 1.008*2088 over 2088 plus code
// - Ideality code is eight-bit two's complement
// - Ideality registers reset to zero
// - Ideality code sits in bits 15:8
// - Remote results get channel offset added
// - Independent offset register per remote channel
// - Offset uses temperature result format
// - One hysteresis register serves all comparisons
// - Hysteresis unsigned, one degree steps
// - Flag clears only after retreating hysteresis
// - Independent primary and secondary limits per channel
// - Limits half degree, +255.5 to -256
// - Limit 255.5 disables compare and flag
// - Pointers 80h-84h mirror temperature results
// - Mirror pointer auto-increments per word read
// - Key 5CA6h locks protected registers
// - Key EB19h unlocks protected registers
// - Lock reads 8000h locked, 0000h unlocked
// - Maker code at FEh, device code FFh
// - Device code upper byte is revision
// ------------------------------------------------------------
`timescale 1ns/1ns
module tsclr_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h0A5A, // arbitrary value
    parameter logic [7:0] PART_CODE = 8'h37, // arbitrary value
    parameter logic [7:0] REVISION = 8'h01 // arbitrary value
) (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic ptr_wr, // load pointer
    input wire logic [7:0] ptr_data, // new pointer value
    input wire logic reg_wr, // write word at pointer
    input wire logic [15:0] reg_wdata, // word to write
    input wire logic reg_rd_ack, // word at pointer was sent
    output logic [15:0] reg_rdata, // word at pointer
    output logic block_mode, // pointer in mirror range
    output logic locked, // protected registers locked
    input wire logic conv_done, // raw result valid
    input wire logic [2:0] conv_ch, // channel of raw result
    input wire logic [15:0] conv_raw, // raw result
    input wire logic [2:0] conv_sel, // channel being converted
    output logic [11:0] ideality_denom, // 2088 plus adjust code
    output logic [4:0] primary_status, // primary limit flags
    output logic [4:0] secondary_status, // secondary limit flags
    output logic overtemp_output_primary_oe_n, // low pulls pin low
    output logic overtemp_output_secondary_oe_n // low pulls pin low
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ptr;
        logic locked;
        logic [15:0] hyst;
        logic [4:0][15:0] lim_p;
        logic [4:0][15:0] lim_s;
        logic [3:0][15:0] offs;
        logic [3:0][15:0] eta;
        logic [4:0][15:0] temp;
        logic [4:0] cmp_go;
        logic [15:0] rdata;
        logic [11:0] denom;
    } tsclr_state_t;

    tsclr_state_t s;
    tsclr_state_t n;
    logic in_mirror;

    assign in_mirror = (s.ptr >= tsclr_pkg::PTR_MIRROR_FIRST)
        && (s.ptr <= tsclr_pkg::PTR_MIRROR_LAST);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [7:0] code;
        code = 8'h00;
        n = s;

        // Read word, refreshed every cycle from the pointer
        n.rdata = tsclr_pkg::UNMAPPED_READ;
        if (s.ptr == tsclr_pkg::PTR_HYST)
        begin
            n.rdata = s.hyst;
        end
        for (int i = 0; i < tsclr_pkg::NUM_CH; i++)
        begin
            if (s.ptr == tsclr_pkg::PTR_LIM_P[i])
            begin
                n.rdata = s.lim_p[i];
            end
            if (s.ptr == tsclr_pkg::PTR_LIM_S[i])
            begin
                n.rdata = s.lim_s[i];
            end
            if (s.ptr == tsclr_pkg::PTR_MIRROR_FIRST + 8'(i))
            begin
                n.rdata = s.temp[i];
            end
        end
        for (int i = 0; i < tsclr_pkg::NUM_REMOTE; i++)
        begin
            if (s.ptr == tsclr_pkg::PTR_OFFS[i])
            begin
                n.rdata = s.offs[i];
            end
            if (s.ptr == tsclr_pkg::PTR_ETA[i])
            begin
                n.rdata = s.eta[i];
            end
        end
        if (s.ptr == tsclr_pkg::PTR_LOCK)
        begin
            n.rdata = s.locked ? tsclr_pkg::LOCK_READ_ON
                : tsclr_pkg::LOCK_READ_OFF;
        end
        if (s.ptr == tsclr_pkg::PTR_MAKER)
        begin
            n.rdata = MAKER_CODE;
        end
        if (s.ptr == tsclr_pkg::PTR_PART)
        begin
            n.rdata = {REVISION, PART_CODE};
        end

        // Host writes; mirror and identity words are read-only
        if (reg_wr)
        begin
            for (int i = 0; i < tsclr_pkg::NUM_REMOTE; i++)
            begin
                if (s.ptr == tsclr_pkg::PTR_OFFS[i])
                begin
                    n.offs[i] = reg_wdata;
                end
                if (s.ptr == tsclr_pkg::PTR_ETA[i])
                begin
                    n.eta[i] = reg_wdata;
                end
            end
            // Lock guards hysteresis and limits only
            if (!s.locked)
            begin
                if (s.ptr == tsclr_pkg::PTR_HYST)
                begin
                    n.hyst = reg_wdata;
                end
                for (int i = 0; i < tsclr_pkg::NUM_CH; i++)
                begin
                    if (s.ptr == tsclr_pkg::PTR_LIM_P[i])
                    begin
                        n.lim_p[i] = reg_wdata;
                    end
                    if (s.ptr == tsclr_pkg::PTR_LIM_S[i])
                    begin
                        n.lim_s[i] = reg_wdata;
                    end
                end
            end
            if (s.ptr == tsclr_pkg::PTR_LOCK)
            begin
                // Any other value leaves the lock as it was
                if (reg_wdata == tsclr_pkg::KEY_LOCK)
                begin
                    n.locked = 1'b1;
                end
                else if (reg_wdata == tsclr_pkg::KEY_UNLOCK)
                begin
                    n.locked = 1'b0;
                end
            end
        end

        // Pointer load wins over block advance
        if (ptr_wr)
        begin
            n.ptr = ptr_data;
        end
        else if (reg_rd_ack && in_mirror)
        begin
            if (s.ptr == tsclr_pkg::PTR_MIRROR_LAST)
            begin
                n.ptr = tsclr_pkg::PTR_MIRROR_FIRST;
            end
            else
            begin
                n.ptr = s.ptr + 8'h01;
            end
        end

        // Store results; local result is kept as measured
        n.cmp_go = 5'h00;
        if (conv_done)
        begin
            if (conv_ch == 3'h0)
            begin
                n.temp[0] = conv_raw;
                n.cmp_go[0] = 1'b1;
            end
            for (int i = 0; i < tsclr_pkg::NUM_REMOTE; i++)
            begin
                if (conv_ch == 3'(i + 1))
                begin
                    n.temp[i + 1] = conv_raw + s.offs[i];
                    n.cmp_go[i + 1] = 1'b1;
                end
            end
        end

        // Denominator of the ideality equation for the active channel
        n.denom = tsclr_pkg::ETA_NOMINAL_DENOM;
        for (int i = 0; i < tsclr_pkg::NUM_REMOTE; i++)
        begin
            if (conv_sel == 3'(i + 1))
            begin
                code = s.eta[i][tsclr_pkg::ETA_MSB:tsclr_pkg::ETA_LSB];
                n.denom = tsclr_pkg::ETA_NOMINAL_DENOM
                    + {{4{code[7]}}, code};
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s.ptr <= tsclr_pkg::PTR_RESET;
            s.locked <= 1'b0;
            s.hyst <= tsclr_pkg::HYST_RESET;
            s.lim_p <= {tsclr_pkg::NUM_CH{tsclr_pkg::LIM_RESET}};
            s.lim_s <= {tsclr_pkg::NUM_CH{tsclr_pkg::LIM_RESET}};
            s.offs <= {tsclr_pkg::NUM_REMOTE{tsclr_pkg::OFFS_RESET}};
            s.eta <= {tsclr_pkg::NUM_REMOTE{tsclr_pkg::ETA_RESET}};
            s.temp <= {tsclr_pkg::NUM_CH{tsclr_pkg::TEMP_RESET}};
            s.cmp_go <= 5'h00;
            s.rdata <= tsclr_pkg::UNMAPPED_READ;
            s.denom <= tsclr_pkg::ETA_NOMINAL_DENOM;
        end
        else
        begin
            s <= n;
        end
    end

    // ------------------------------------------------------------
    // Limit comparators
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < tsclr_pkg::NUM_CH; g++)
        begin : g_ch
            tsclr_limit_cmp u_primary (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .sample(s.cmp_go[g]),
                .temp_code(s.temp[g][tsclr_pkg::TEMP_MSB:tsclr_pkg::TEMP_LSB]),
                .limit_code(s.lim_p[g][tsclr_pkg::LIM_MSB:tsclr_pkg::LIM_LSB]),
                .hyst_code(s.hyst[tsclr_pkg::HYST_MSB:tsclr_pkg::HYST_LSB]),
                .over(primary_status[g])
            );
            tsclr_limit_cmp u_secondary (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .sample(s.cmp_go[g]),
                .temp_code(s.temp[g][tsclr_pkg::TEMP_MSB:tsclr_pkg::TEMP_LSB]),
                .limit_code(s.lim_s[g][tsclr_pkg::LIM_MSB:tsclr_pkg::LIM_LSB]),
                .hyst_code(s.hyst[tsclr_pkg::HYST_MSB:tsclr_pkg::HYST_LSB]),
                .over(secondary_status[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign block_mode = in_mirror;
    assign locked = s.locked;
    assign ideality_denom = s.denom;
    // Open-drain pins: data is always low, only the enable moves
    assign overtemp_output_primary_oe_n = ~|primary_status;
    assign overtemp_output_secondary_oe_n = ~|secondary_status;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    property p_lock_key;
        reg_wr && (s.ptr == tsclr_pkg::PTR_LOCK)
            && (reg_wdata == tsclr_pkg::KEY_LOCK) |=> locked;
    endproperty
    a_lock_key: assert property (p_lock_key)
        else $error("lock key did not lock");

    property p_unlock_key;
        reg_wr && (s.ptr == tsclr_pkg::PTR_LOCK)
            && (reg_wdata == tsclr_pkg::KEY_UNLOCK) |=> !locked;
    endproperty
    a_unlock_key: assert property (p_unlock_key)
        else $error("unlock key did not unlock");

    property p_lock_read;
        (s.ptr == tsclr_pkg::PTR_LOCK) |=> reg_rdata == ($past(s.locked)
            ? tsclr_pkg::LOCK_READ_ON : tsclr_pkg::LOCK_READ_OFF);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock word read wrong");

    property p_locked_ignore;
        locked && reg_wr && (s.ptr == tsclr_pkg::PTR_LIM_P[1])
            |=> $stable(s.lim_p[1]);
    endproperty
    a_locked_ignore: assert property (p_locked_ignore)
        else $error("protected limit written while locked");

    property p_offset_add;
        conv_done && (conv_ch == 3'h2)
            |=> s.temp[2] == 16'($past(conv_raw) + $past(s.offs[1]));
    endproperty
    a_offset_add: assert property (p_offset_add)
        else $error("offset not added to remote result");

    property p_block_inc;
        in_mirror && reg_rd_ack && !ptr_wr
            && (s.ptr != tsclr_pkg::PTR_MIRROR_LAST)
            |=> s.ptr == 8'($past(s.ptr) + 8'h01);
    endproperty
    a_block_inc: assert property (p_block_inc)
        else $error("mirror pointer did not advance");

    property p_mirror_read;
        (s.ptr == tsclr_pkg::PTR_MIRROR_FIRST) ##1 (s.ptr == $past(s.ptr))
            |=> reg_rdata == $past(s.temp[0]);
    endproperty
    a_mirror_read: assert property (p_mirror_read)
        else $error("mirror word differs from result");

    property p_eta_denom;
        (conv_sel == 3'h3) |=> ideality_denom == 12'(tsclr_pkg::ETA_NOMINAL_DENOM
            + {{4{$past(s.eta[2][15])}}, $past(s.eta[2][15:8])});
    endproperty
    a_eta_denom: assert property (p_eta_denom)
        else $error("ideality denominator wrong");

    property p_eta_local;
        (conv_sel == 3'h0) |=> ideality_denom == tsclr_pkg::ETA_NOMINAL_DENOM;
    endproperty
    a_eta_local: assert property (p_eta_local)
        else $error("local channel took an ideality code");

    property p_revision;
        (s.ptr == tsclr_pkg::PTR_PART) |=> reg_rdata[15:8] == REVISION;
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision byte wrong");

    c_lock: cover property ($rose(locked));
    c_wrap: cover property (reg_rd_ack && (s.ptr == tsclr_pkg::PTR_MIRROR_LAST));
    c_trip: cover property ($fell(overtemp_output_primary_oe_n));
    c_adjust: cover property (ideality_denom != tsclr_pkg::ETA_NOMINAL_DENOM);
endmodule : tsclr_regs
